// >>> hw/bgs_ctrl.sv
`timescale 1ns/100ps
module bgs_ctrl
    import bgs_pkg::*;
#(
    parameter int SSDLY_CYC = 10000,
    parameter int RES_FILT = 4,
    parameter int EN_FILT = 4
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Enable pin and comparator flags
    input wire logic enable_pin,
    input wire logic cur_limit,
    input wire logic sw_low,
    input wire logic out_below_uv,
    input wire logic out_above_ov,
    input wire logic out_below_reg,
    input wire logic out_near_zero,
    input wire logic low_input_condition,
    input wire logic comp_low,
    input wire logic pwm_demand_end,
    input wire logic diode_emulation,
    // Reset pin current in microamps
    input wire logic [9:0] reset_pin_current,
    // Gate drives
    output logic high_side_gate,
    output logic low_side_gate,
    // Open-drain reset pin
    output logic reset_out_n_pin_o,
    output logic reset_out_n_pin_oe,
    // Discharge and status
    output logic ov_discharge_en,
    output logic softstart_go,
    output logic low_iq_mode,
    output logic [1:0] clamp_sel
);
    logic en_s, cl_s, sw_s, uv_s, ov_s, reg_s, nz_s, li_s, cmp_s, de_end_s, de_s;
    bgs_state_t st_r, st_nxt;
    bgs_phase_t ph_r, ph_nxt;
    logic [CNT_W-1:0] per_r, per_nxt, tm_r, tm_nxt;
    logic [DLY_W-1:0] dly_r, dly_nxt;
    logic [3:0] bcnt_r, bcnt_nxt;
    logic [1:0] burst_r, burst_nxt;
    logic skip_r, skip_nxt, hs_r, hs_nxt, ls_r, ls_nxt, lsk_r, lsk_nxt;
    logic [DLY_W-1:0] rdly_r, rdly_nxt;
    logic [7:0] rfilt_r, rfilt_nxt;
    logic rst_lo_r, rst_lo_nxt;
    logic [CNT_W-1:0] ov_cnt_r, ov_cnt_nxt;
    logic ovd_r, ovd_nxt;
    logic [DLY_W-1:0] rel_cyc;
    logic tick;

    // Every flag is synchronised before use, enable gets a longer filter
    bgs_sync #(.FILT(EN_FILT)) u_en (.clock(clock), .rst(rst), .raw(enable_pin), .filt(en_s));
    bgs_sync u_cl (.clock(clock), .rst(rst), .raw(cur_limit), .filt(cl_s));
    bgs_sync u_sw (.clock(clock), .rst(rst), .raw(sw_low), .filt(sw_s));
    bgs_sync u_uv (.clock(clock), .rst(rst), .raw(out_below_uv), .filt(uv_s));
    bgs_sync u_ov (.clock(clock), .rst(rst), .raw(out_above_ov), .filt(ov_s));
    bgs_sync u_rg (.clock(clock), .rst(rst), .raw(out_below_reg), .filt(reg_s));
    bgs_sync u_nz (.clock(clock), .rst(rst), .raw(out_near_zero), .filt(nz_s));
    bgs_sync u_li (.clock(clock), .rst(rst), .raw(low_input_condition), .filt(li_s));
    bgs_sync u_cm (.clock(clock), .rst(rst), .raw(comp_low), .filt(cmp_s));
    bgs_sync u_de (.clock(clock), .rst(rst), .raw(pwm_demand_end), .filt(de_end_s));
    bgs_sync u_dm (.clock(clock), .rst(rst), .raw(diode_emulation), .filt(de_s));

    // Oscillator tick, every switching period (runs in all active states)
    assign tick = (per_r == CNT_W'(PWM_PERIOD_CYC - 1));

    // Release delay: 9.9/(4*I mA) ms = 9.9*CLK_HZ/(4*I uA) cycles; none at 500 uA and up
    always_comb
    begin
        if (reset_pin_current >= 10'd500 || reset_pin_current == 10'd0)
            rel_cyc = '0;
        else
            rel_cyc = DLY_W'((RST_NUM_X10 * (CLK_HZ / 10)) / (RST_DEN * int'(reset_pin_current)));
    end

    // Sequencer next state
    always_comb
    begin
        st_nxt = st_r;
        ph_nxt = ph_r;
        per_nxt = tick ? '0 : per_r + CNT_W'(1);
        tm_nxt = tm_r;
        dly_nxt = dly_r;
        bcnt_nxt = bcnt_r;
        burst_nxt = burst_r;
        skip_nxt = skip_r;
        lsk_nxt = lsk_r;
        hs_nxt = 1'b0;
        ls_nxt = 1'b0;
        case (st_r)
            BGS_OFF:
            begin
                per_nxt = '0;
                if (en_s)
                begin
                    st_nxt = BGS_DELAY;
                    dly_nxt = '0;
                end
            end
            BGS_DELAY:
            begin
                dly_nxt = dly_r + DLY_W'(1);
                if (!en_s)
                    st_nxt = BGS_OFF;
                else if (dly_r >= DLY_W'(SSDLY_CYC - 1))
                begin
                    st_nxt = nz_s ? BGS_RUN : BGS_BOOT;
                    tm_nxt = '0;
                    bcnt_nxt = '0;
                    ph_nxt = PH_ON;
                    skip_nxt = 1'b0;
                    burst_nxt = 2'd0;
                end
            end
            BGS_BOOT:
            begin
                // Low-side only, high-side held off
                tm_nxt = tm_r + CNT_W'(1);
                ls_nxt = (tm_r < CNT_W'(BOOT_WIDTH_CYC));
                if (tm_r == CNT_W'(BOOT_PERIOD_CYC - 1))
                begin
                    tm_nxt = '0;
                    bcnt_nxt = bcnt_r + 4'd1;
                    if (bcnt_r == 4'(BOOT_PULSES - 1))
                    begin
                        st_nxt = BGS_RUN;
                        ph_nxt = PH_ON;
                    end
                end
                if (!en_s)
                begin
                    st_nxt = BGS_STOP;
                    dly_nxt = '0;
                end
            end
            BGS_RUN, BGS_STOP:
            begin
                tm_nxt = tm_r + CNT_W'(1);
                // Period count paces the quarter-rate burst
                if (tick)
                    bcnt_nxt = bcnt_r + 4'd1;
                // Pulse skip from error amp low, not from current sense
                if (cmp_s && de_s && !skip_r)
                    skip_nxt = 1'b1;
                else if (skip_r && !cmp_s)
                begin
                    skip_nxt = 1'b0;
                    burst_nxt = 2'(BURST_PULSES);
                end
                case (ph_r)
                    PH_ON:
                    begin
                        hs_nxt = 1'b1;
                        if (cl_s)
                        begin
                            hs_nxt = 1'b0;
                            ph_nxt = PH_WAIT;
                            tm_nxt = '0;
                        end
                        else if (li_s && reg_s)
                        begin
                            if (tm_r >= CNT_W'(LOWIN_ON_CYC - 1))
                            begin
                                hs_nxt = 1'b0;
                                ph_nxt = PH_WAIT;
                                tm_nxt = '0;
                            end
                        end
                        else if (de_end_s || (per_r >= CNT_W'(PWM_PERIOD_CYC - 1 - MIN_OFF_CYC) && !li_s))
                        begin
                            hs_nxt = 1'b0;
                            ph_nxt = PH_WAIT;
                            tm_nxt = '0;
                        end
                        // Pulse skip ends the on-time at once; during a burst it ends at half a period
                        if (skip_r || (burst_r != 2'd0 && tm_r >= CNT_W'(PWM_PERIOD_CYC / 2)))
                        begin
                            hs_nxt = 1'b0;
                            ph_nxt = PH_WAIT;
                            tm_nxt = '0;
                        end
                    end
                    PH_WAIT:
                    begin
                        // Switch node must fall within the wait window
                        if (sw_s)
                        begin
                            ls_nxt = 1'b1;
                            ph_nxt = PH_LS;
                            lsk_nxt = 1'b0;
                        end
                        else if (tm_r >= CNT_W'(SW_WAIT_CYC - 1))
                        begin
                            ls_nxt = 1'b1;
                            ph_nxt = PH_LS;
                            lsk_nxt = 1'b1;
                            tm_nxt = '0;
                        end
                    end
                    default:
                    begin
                        // Forced pulse is fixed width; normal low side lasts to next start
                        ls_nxt = lsk_r ? (tm_r < CNT_W'(FORCE_LS_CYC - 1)) : 1'b1;
                        if (lsk_r && tm_r >= CNT_W'(FORCE_LS_CYC - 1))
                            lsk_nxt = 1'b0;
                        // Off time counts from the high side falling, or from the forced pulse when the node stays high
                        if (tick || (li_s && reg_s && tm_r >= CNT_W'(LOWIN_OFF_CYC - 2)))
                        begin
                            if (burst_r != 2'd0 && bcnt_r[1:0] != 2'b00)
                                ph_nxt = PH_LS; // quarter-rate burst waits
                            else
                            begin
                                ls_nxt = 1'b0;
                                hs_nxt = !skip_r;
                                ph_nxt = PH_ON;
                                tm_nxt = '0;
                                if (burst_r != 2'd0)
                                    burst_nxt = burst_r - 2'd1;
                                if (cl_s)
                                begin
                                    ph_nxt = PH_WAIT;
                                    ls_nxt = 1'b1;
                                    hs_nxt = 1'b0;
                                end
                            end
                        end
                    end
                endcase
                if (st_r == BGS_RUN && !en_s)
                begin
                    st_nxt = BGS_STOP;
                    dly_nxt = '0;
                end
                else if (st_r == BGS_STOP)
                begin
                    dly_nxt = dly_r + DLY_W'(1);
                    if (dly_r >= DLY_W'(EN_OFF_CYC - 1))
                    begin
                        st_nxt = BGS_OFF;
                        hs_nxt = 1'b0;
                        ls_nxt = 1'b0;
                    end
                    else if (en_s)
                        st_nxt = BGS_RUN;
                end
            end
            default: st_nxt = BGS_OFF;
        endcase
    end

    // Reset output filter, release delay and overvoltage discharge
    always_comb
    begin
        rst_lo_nxt = rst_lo_r;
        rfilt_nxt = '0;
        rdly_nxt = '0;
        ov_cnt_nxt = '0;
        ovd_nxt = 1'b0;
        if (st_r == BGS_OFF)
            rst_lo_nxt = 1'b1;
        else if (uv_s || ov_s)
        begin
            rfilt_nxt = rfilt_r + 8'h01;
            if (rfilt_r >= 8'(RES_FILT - 1))
            begin
                rst_lo_nxt = 1'b1;
                rfilt_nxt = rfilt_r;
            end
        end
        else if (rst_lo_r)
        begin
            rdly_nxt = rdly_r + DLY_W'(1);
            if (rdly_r >= rel_cyc)
                rst_lo_nxt = 1'b0;
        end
        // Discharge engages well inside the response limit
        if (ov_s && st_r != BGS_OFF)
        begin
            ov_cnt_nxt = (ov_cnt_r < CNT_W'(OV_DIS_CYC)) ? ov_cnt_r + CNT_W'(1) : ov_cnt_r;
            ovd_nxt = 1'b1;
        end
    end

    // Registers
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            st_r <= BGS_OFF;
            ph_r <= PH_ON;
            per_r <= '0;
            tm_r <= '0;
            dly_r <= '0;
            bcnt_r <= 4'h0;
            burst_r <= 2'h0;
            skip_r <= 1'b0;
            lsk_r <= 1'b0;
            hs_r <= 1'b0;
            ls_r <= 1'b0;
            rdly_r <= '0;
            rfilt_r <= 8'h00;
            rst_lo_r <= 1'b1;
            ov_cnt_r <= '0;
            ovd_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            ph_r <= ph_nxt;
            per_r <= per_nxt;
            tm_r <= tm_nxt;
            dly_r <= dly_nxt;
            bcnt_r <= bcnt_nxt;
            burst_r <= burst_nxt;
            skip_r <= skip_nxt;
            lsk_r <= lsk_nxt;
            hs_r <= hs_nxt;
            ls_r <= ls_nxt;
            rdly_r <= rdly_nxt;
            rfilt_r <= rfilt_nxt;
            rst_lo_r <= rst_lo_nxt;
            ov_cnt_r <= ov_cnt_nxt;
            ovd_r <= ovd_nxt;
        end
    end

    // Outputs; gates never overlap since only one is set per phase
    assign high_side_gate = hs_r && !ls_r;
    assign low_side_gate = ls_r;
    assign reset_out_n_pin_o = 1'b0;
    assign reset_out_n_pin_oe = rst_lo_r;
    assign ov_discharge_en = ovd_r;
    assign softstart_go = (st_r == BGS_RUN);
    assign low_iq_mode = skip_r && de_s;
    // Clamp: 0 none, 1 skip level, 2 burst level
    assign clamp_sel = (st_r != BGS_RUN) ? 2'd0 : (burst_r != 2'd0) ? 2'd2 : skip_r ? 2'd1 : 2'd0;

    // Checks
    property p_boot_no_hs;
        @(posedge clock) disable iff (rst) (st_r == BGS_BOOT) |-> !high_side_gate;
    endproperty
    a_boot_no_hs: assert property (p_boot_no_hs) else $error("high side during pre-charge");

    property p_cl_ends;
        @(posedge clock) disable iff (rst) (st_r == BGS_RUN && ph_r == PH_ON && cl_s) |=> !high_side_gate;
    endproperty
    a_cl_ends: assert property (p_cl_ends) else $error("current limit did not end on-time");

    property p_ov_dis;
        @(posedge clock) disable iff (rst) (ov_s && st_r != BGS_OFF) |=> ov_discharge_en;
    endproperty
    a_ov_dis: assert property (p_ov_dis) else $error("discharge not enabled");

    property p_off_quiet;
        @(posedge clock) disable iff (rst) (st_r == BGS_OFF) |=> !high_side_gate && !low_side_gate;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("gates active in shutdown");

    property p_force_ls;
        @(posedge clock) disable iff (rst) (ph_r == PH_WAIT && !sw_s && tm_r == '0 && st_r == BGS_RUN) |=> ##[0:1] low_side_gate;
    endproperty
    a_force_ls: assert property (p_force_ls) else $error("low side not forced");

    property p_reset_low;
        @(posedge clock) disable iff (rst) (uv_s && st_r == BGS_RUN) [*4] |=> reset_out_n_pin_oe;
    endproperty
    a_reset_low: assert property (p_reset_low) else $error("reset not asserted");

    property p_stop_bound;
        @(posedge clock) disable iff (rst) (st_r == BGS_STOP && $past(st_r) == BGS_RUN && !en_s) |-> ##[1:151] (st_r != BGS_STOP);
    endproperty
    a_stop_bound: assert property (p_stop_bound) else $error("switching did not stop");

    property p_no_overlap;
        @(posedge clock) disable iff (rst) !(high_side_gate && low_side_gate);
    endproperty
    a_no_overlap: assert property (p_no_overlap) else $error("gate overlap");

    property p_delay;
        @(posedge clock) disable iff (rst) $rose(en_s) && st_r == BGS_OFF |=> !softstart_go [*8];
    endproperty
    a_delay: assert property (p_delay) else $error("soft-start before delay");
endmodule

// >>> hw/bgs_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser with a settle filter on the clean side
module bgs_sync #(
    parameter int FILT = 1
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Raw level and filtered level
    input wire logic raw,
    output logic filt
);
    logic meta_r;
    logic sync_r;
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic filt_nxt;

    // Filter counts agreement of the clean sample before switching
    always_comb
    begin
        cnt_nxt = 8'h00;
        filt_nxt = filt;
        if (sync_r != filt)
        begin
            cnt_nxt = cnt_r + 8'h01;
            if (cnt_r >= 8'(FILT - 1))
            begin
                filt_nxt = sync_r;
                cnt_nxt = 8'h00;
            end
        end
    end

    // Metastable flop feeds only the second flop
    always_ff @(posedge clock or posedge rst)
    begin
        if (rst)
        begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            cnt_r <= 8'h00;
            filt <= 1'b0;
        end
        else
        begin
            meta_r <= raw;
            sync_r <= meta_r;
            cnt_r <= cnt_nxt;
            filt <= filt_nxt;
        end
    end
endmodule

// >>> shared/bgs_pkg.sv
package bgs_pkg;
    // Clock rate and period
    localparam int CLK_HZ = 10000000;
    localparam int CLK_NS = 1000000000 / CLK_HZ;
    // Switching period, 2 MHz
    localparam int PWM_PERIOD_NS = 500;
    localparam int PWM_PERIOD_CYC = PWM_PERIOD_NS / CLK_NS;
    // Bootstrap pre-charge train
    localparam int BOOT_PULSES = 8;
    localparam int BOOT_WIDTH_NS = 250;
    localparam int BOOT_WIDTH_CYC = (BOOT_WIDTH_NS + CLK_NS - 1) / CLK_NS;
    localparam int BOOT_PERIOD_NS = 2000;
    localparam int BOOT_PERIOD_CYC = BOOT_PERIOD_NS / CLK_NS;
    // Low input long on-time and short off-time
    localparam int LOWIN_ON_NS = 16000;
    localparam int LOWIN_ON_CYC = LOWIN_ON_NS / CLK_NS;
    localparam int LOWIN_OFF_NS = 200;
    localparam int LOWIN_OFF_CYC = (LOWIN_OFF_NS + CLK_NS - 1) / CLK_NS;
    // Switch-node wait and forced low-side width
    localparam int SW_WAIT_NS = 70;
    localparam int SW_WAIT_CYC = (SW_WAIT_NS / CLK_NS) < 1 ? 1 : SW_WAIT_NS / CLK_NS;
    localparam int FORCE_LS_NS = 100;
    localparam int FORCE_LS_CYC = (FORCE_LS_NS + CLK_NS - 1) / CLK_NS;
    // Minimum high-side off time in the normal period
    localparam int MIN_OFF_CYC = 1;
    // Enable-low to switching stop
    localparam int EN_OFF_NS = 15000;
    localparam int EN_OFF_CYC = EN_OFF_NS / CLK_NS;
    // Overvoltage discharge response
    localparam int OV_DIS_NS = 2700;
    localparam int OV_DIS_CYC = OV_DIS_NS / CLK_NS;
    // Slow restart burst: up to three pulses at a quarter rate
    localparam int BURST_PULSES = 3;
    localparam int BURST_DIV = 4;
    // Counter widths
    localparam int CNT_W = 16;
    localparam int DLY_W = 32;
    // Reset release: delay ms = 9.9 / (4 * current mA), in cycles per tenth-unit
    localparam int RST_NUM_X10 = 99;
    localparam int RST_DEN = 4;
    // Drive state
    typedef enum logic [2:0] {
        BGS_OFF = 3'b000,
        BGS_DELAY = 3'b001,
        BGS_BOOT = 3'b011,
        BGS_RUN = 3'b010,
        BGS_STOP = 3'b110
    } bgs_state_t;
    // Switching phase
    typedef enum logic [1:0] {
        PH_ON = 2'b00,
        PH_WAIT = 2'b01,
        PH_LS = 2'b11
    } bgs_phase_t;
endpackage

// >>> testbench/bgs_fet_model.sv
`timescale 1ns/100ps
// Power stage and reset pull-up as seen from the gate and reset pins
module bgs_fet_model (
    // Clock and gate drives
    input wire logic clock,
    input wire logic high_side_gate,
    input wire logic low_side_gate,
    // Light load: node lingers high after the high side opens
    input wire logic slow_sw,
    // Open-drain reset pin
    input wire logic pin_o,
    input wire logic pin_oe,
    // Switch-node comparator and reset line level
    output logic sw_low,
    output logic reset_level
);
    logic hs_d;
    // Node decays a cycle after high-side off; only the low side pulls it down under light load
    always_ff @(posedge clock)
        hs_d <= high_side_gate;
    assign sw_low = low_side_gate | (!high_side_gate && !hs_d && !slow_sw);
    // Pull-up wins whenever nobody pulls low
    assign reset_level = pin_oe ? pin_o : 1'b1;
endmodule

// >>> testbench/tb_bgs_ctrl.sv
`timescale 1ns/100ps
module tb_bgs_ctrl;
    import bgs_pkg::*;
    localparam int SSD = 20;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic enable_pin = 1'b0, cur_limit = 1'b0, out_below_uv = 1'b0, out_above_ov = 1'b0;
    logic out_below_reg = 1'b0, out_near_zero = 1'b0, low_input_condition = 1'b0, comp_low = 1'b0;
    logic pwm_demand_end = 1'b0, diode_emulation = 1'b0, slow_sw = 1'b0;
    logic [9:0] reset_pin_current = 10'h3e8;
    logic sw_low, hsg, lsg, pin_o, pin_oe, ov_discharge_en, softstart_go, low_iq_mode, reset_level;
    logic [1:0] clamp_sel;
    int bad_count = 0;
    int n_checks = 0;
    int n, a, b;
    // Clock
    always #50 clock = ~clock;
    // Block and its far side
    bgs_ctrl #(.SSDLY_CYC(SSD), .RES_FILT(4), .EN_FILT(4)) i_dut (.clock(clock), .rst(rst),
        .enable_pin(enable_pin), .cur_limit(cur_limit), .sw_low(sw_low), .out_below_uv(out_below_uv),
        .out_above_ov(out_above_ov), .out_below_reg(out_below_reg), .out_near_zero(out_near_zero),
        .low_input_condition(low_input_condition), .comp_low(comp_low), .pwm_demand_end(pwm_demand_end),
        .diode_emulation(diode_emulation), .reset_pin_current(reset_pin_current), .high_side_gate(hsg),
        .low_side_gate(lsg), .reset_out_n_pin_o(pin_o), .reset_out_n_pin_oe(pin_oe),
        .ov_discharge_en(ov_discharge_en), .softstart_go(softstart_go), .low_iq_mode(low_iq_mode),
        .clamp_sel(clamp_sel));
    bgs_fet_model i_fet (.clock(clock), .high_side_gate(hsg), .low_side_gate(lsg), .slow_sw(slow_sw),
        .pin_o(pin_o), .pin_oe(pin_oe), .sw_low(sw_low), .reset_level(reset_level));
    // Compare and count
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("MISMATCH at %0t: saw %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic final_report();
        if (bad_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // End of a bounded wait; a hang ends the run
    task automatic waited(input logic ok);
        check(ok, 1'b1);
        if (ok !== 1'b1)
            final_report();
    endtask
    task automatic cyc(input int k);
        repeat (k) @(negedge clock);
    endtask
    // Count high samples of both gates
    task automatic sample(input int k, output int h, output int l);
        h = 0;
        l = 0;
        repeat (k)
        begin
            @(negedge clock);
            h += (hsg === 1'b1);
            l += (lsg === 1'b1);
        end
    endtask
    // Enable rise, start delay, bootstrap train
    task automatic boot_train();
        int wid = 0;
        int rises = 0;
        int hs = 0;
        int last = 0;
        logic prev = 1'b0;
        @(posedge clock) enable_pin <= 1'b1;
        cyc(SSD);
        check(softstart_go, 1'b0);
        for (n = 0; n < 600 && softstart_go !== 1'b1; n++)
        begin
            @(negedge clock);
            hs += (hsg === 1'b1);
            if (lsg === 1'b1 && prev !== 1'b1)
            begin
                if (rises > 0)
                    check(n - last, BOOT_PERIOD_CYC);
                rises++;
                last = n;
            end
            if (lsg === 1'b1)
                wid++;
            else if (prev === 1'b1)
            begin
                check(wid, BOOT_WIDTH_CYC);
                wid = 0;
            end
            prev = lsg;
        end
        waited(softstart_go);
        check(rises, BOOT_PULSES);
        check(hs, 0);
        check(clamp_sel, 2'h0);
    endtask
    // Held current limit: high side skipped, low side keeps going
    task automatic cur_limit_skip();
        @(posedge clock) cur_limit <= 1'b1;
        cyc(8);
        sample(20, a, b);
        check(a, 0);
        check(b > 0, 1'b1);
        @(posedge clock) cur_limit <= 1'b0;
        for (n = 0; n < 20 && hsg !== 1'b1; n++) @(negedge clock);
        waited(hsg);
    endtask
    // Output window, discharge and reset pin timing
    task automatic out_window();
        @(posedge clock) out_below_uv <= 1'b1;
        repeat (2) @(posedge clock);
        out_below_uv <= 1'b0;
        cyc(12);
        check(reset_level, 1'b1);
        @(posedge clock) out_above_ov <= 1'b1;
        for (n = 0; n < OV_DIS_CYC && ov_discharge_en !== 1'b1; n++) @(negedge clock);
        waited(ov_discharge_en);
        for (n = 0; n < 12 && reset_level !== 1'b0; n++) @(negedge clock);
        waited(!reset_level);
        // Full-scale pin current: power-good, no release delay
        @(posedge clock) out_above_ov <= 1'b0;
        for (n = 0; n < 12 && reset_level !== 1'b1; n++) @(negedge clock);
        waited(reset_level);
        check(ov_discharge_en, 1'b0);
        @(posedge clock) out_below_uv <= 1'b1;
        reset_pin_current <= 10'h190;
        cyc(12);
        check(reset_level, 1'b0);
        @(posedge clock) out_below_uv <= 1'b0;
        cyc(7000);
        check(reset_level, 1'b0);
    endtask
    // Low input and light load: long on, short off, forced low side
    task automatic low_input();
        @(posedge clock) low_input_condition <= 1'b1;
        out_below_reg <= 1'b1;
        slow_sw <= 1'b1;
        cyc(8);
        for (n = 0; n < 200 && hsg !== 1'b0; n++) @(negedge clock);
        for (n = 0; n < 40 && hsg !== 1'b1; n++) @(negedge clock);
        waited(hsg);
        for (a = 0; a < 200 && hsg === 1'b1; a++) @(negedge clock);
        check(a >= LOWIN_ON_CYC - 1 && a <= LOWIN_ON_CYC + 1, 1'b1);
        b = 0;
        for (n = 0; n < 10 && hsg !== 1'b1; n++)
        begin
            b += (lsg === 1'b1);
            @(negedge clock);
        end
        check(n >= LOWIN_OFF_CYC && n <= LOWIN_OFF_CYC + 1, 1'b1);
        check(b > 0, 1'b1);
        @(posedge clock) low_input_condition <= 1'b0;
        out_below_reg <= 1'b0;
        slow_sw <= 1'b0;
    endtask
    // Pulse skip, low quiescent mode and clamp selection
    task automatic skip_mode();
        @(posedge clock) comp_low <= 1'b1;
        cyc(12);
        check(low_iq_mode, 1'b0);
        @(posedge clock) diode_emulation <= 1'b1;
        for (n = 0; n < 12 && low_iq_mode !== 1'b1; n++) @(negedge clock);
        waited(low_iq_mode);
        check(clamp_sel, 2'h1);
        @(posedge clock) comp_low <= 1'b0;
        for (n = 0; n < 12 && clamp_sel !== 2'h2; n++) @(negedge clock);
        waited(clamp_sel === 2'h2);
        for (n = 0; n < 100 && clamp_sel !== 2'h0; n++) @(negedge clock);
        waited(clamp_sel === 2'h0);
        @(posedge clock) diode_emulation <= 1'b0;
    endtask
    // Enable glitch, shutdown delay, fresh start
    task automatic enable_cycle();
        @(posedge clock) enable_pin <= 1'b0;
        @(posedge clock) enable_pin <= 1'b1;
        cyc(20);
        check(softstart_go, 1'b1);
        @(posedge clock) enable_pin <= 1'b0;
        cyc(40);
        sample(20, a, b);
        check(a > 0, 1'b1);
        cyc(EN_OFF_CYC);
        sample(20, a, b);
        check(a + b, 0);
        check(softstart_go, 1'b0);
        check(pin_oe, 1'b1);
        boot_train();
    endtask
    // Main sequence
    initial
    begin
        repeat (16) @(posedge clock);
        rst <= 1'b0;
        boot_train();
        cur_limit_skip();
        out_window();
        low_input();
        skip_mode();
        enable_cycle();
        final_report();
    end
endmodule
